// ==== hw/sss_pkg.sv ====
/*
 * shared constants for the sgmii speed status and double code-group port block.
 * assumes a single core clock; link clocks are sampled, not used as clocks.
 */
package sss_pkg;
    // two code groups of ten bits travel per link clock
    localparam int CG_W = 20;
    // forced speed field encodings
    localparam logic [1:0] SPD_1000 = 2'b10;
    localparam logic [1:0] SPD_100 = 2'b01;
    localparam logic [1:0] SPD_10 = 2'b00;
    // partner ability word layout in sgmii mode
    localparam int PA_W = 16;
    localparam int PA_LINK_BIT = 15;
    localparam int PA_DUPLEX_BIT = 12;
    localparam int PA_SPD_HI = 11;
    localparam int PA_SPD_LO = 10;
    // core clock and qualifier spacing at the slow speeds
    localparam int CORE_CLK_MHZ = 50;
    localparam int QUAL_100_NS = 80;
    localparam int QUAL_10_NS = 800;
    localparam int QUAL_100_CYC = (QUAL_100_NS * CORE_CLK_MHZ) / 1000;
    localparam int QUAL_10_CYC = (QUAL_10_NS * CORE_CLK_MHZ) / 1000;
    localparam int QUAL_CNT_W = 8;
    // transmit buffer
    localparam int TX_FIFO_DEPTH = 16;
    // word sent when the transmit buffer runs dry, and reset values
    localparam logic [CG_W-1:0] TX_FILL_WORD = 20'h00000;
    localparam logic [CG_W-1:0] CG_RST_WORD = 20'h00000;
    localparam logic STATUS_RST = 1'b0;
    localparam logic QUAL_RST = 1'b0;
endpackage : sss_pkg

// ==== hw/sss_fifo_if.sv ====
/*
 * valid/ready carrier between the top and its transmit buffer.
 * assumes both sides run on the same core clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface sss_fifo_if #(
    parameter int WIDTH = 20
);
    logic wr_valid;
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;
    modport fifo (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
    modport user (output wr_valid, output wr_data, output rd_ready,
                  input wr_ready, input rd_valid, input rd_data);
endinterface : sss_fifo_if
`default_nettype wire

// ==== hw/sss_fifo.sv ====
/*
 * flip-flop fifo with valid/ready on both sides.
 * assumes synchronous active-high clear supplied by the owner's reset domain.
 */
`timescale 1ns/100ps
`default_nettype none
module sss_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic clr_i,
    sss_fifo_if.fifo port_if
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] count_w;
    wire push_w = port_if.wr_valid & port_if.wr_ready;
    wire pop_w = port_if.rd_valid & port_if.rd_ready;
    assign count_w = wr_ptr_reg - rd_ptr_reg;
    // full and empty straight from the pointer difference
    assign port_if.wr_ready = (count_w != (AW+1)'(DEPTH));
    assign port_if.rd_valid = (count_w != '0);
    assign port_if.rd_data = mem_reg[rd_ptr_reg[AW-1:0]];
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
    // storage needs no reset, only written words are ever read
    always_ff @(posedge clk_i) begin
        if (push_w) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= port_if.wr_data;
        end
    end
endmodule : sss_fifo
`default_nettype wire

// ==== hw/sss_top.sv ====
/*
 * speed and duplex status decode, clock qualifiers and a double code-group
 * port toward an external serializer, with a transmit buffer.
 * assumes the serializer clocks are far slower than the core clock, which
 * samples them; config inputs are static or on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 1000base-x mode: gigabit indicator always one
// - sgmii autoneg: gigabit from partner ability
// - sgmii forced: gigabit when speed field 10
// - 100 indicator zero in 1000base-x, else partner
// - sgmii forced: 100 when speed field 01
// - 10 indicator zero in 1000base-x, else partner
// - sgmii forced: 10 when speed field 00
// - half duplex zero in 1000base-x, else partner
// - sgmii forced: half duplex from duplex bit
// - clock qualifiers pace sgmii whenever gigabit is not set
// - receive reset clears the receive qualifier and capture registers, not the pin samplers
// - transmit reset clears the transmit buffer, word register and qualifier, not the clock sampler
// - double-width code-group port to external serializer
// - two code groups driven per transmit clock
// - receive words captured on core clock at each sampled recovered clock rise
// - receive qualifier gates valid receive activity
module sss_top #(
    parameter int DIV_100 = sss_pkg::QUAL_100_CYC,
    parameter int DIV_10 = sss_pkg::QUAL_10_CYC,
    parameter int FIFO_DEPTH = sss_pkg::TX_FIFO_DEPTH
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic SGMII_MODE_I,
    input wire logic AUTONEG_USE_BIT_I,
    input wire logic [1:0] FORCED_SPEED_I,
    input wire logic FORCED_DUPLEX_I,
    input wire logic [sss_pkg::PA_W-1:0] PARTNER_ABILITY_I,
    output logic SET_1000_O,
    output logic SET_100_O,
    output logic SET_10_O,
    output logic HALF_DUPLEX_IND_O,
    output logic RX_CLKENA_O,
    output logic TX_CLKENA_O,
    input wire logic RX_RESET_I,
    input wire logic TX_RESET_I,
    input wire logic DBL_CODEGROUP_TX_CLOCK_I,
    output logic [sss_pkg::CG_W-1:0] DBL_CODEGROUP_TX_WORD_O,
    input wire logic DBL_CODEGROUP_RX_CLOCK_I,
    input wire logic [sss_pkg::CG_W-1:0] DBL_CODEGROUP_RX_WORD_I,
    input wire logic [sss_pkg::CG_W-1:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    output logic [sss_pkg::CG_W-1:0] RX_DATA_O,
    output logic RX_VALID_O
);
    import sss_pkg::*;

    // pin synchronisers; first stages feed only the second stages
    logic rx_rst_s1_reg;
    logic rx_rst_s2_reg;
    logic tx_rst_s1_reg;
    logic tx_rst_s2_reg;
    logic rx_clk_s1_reg;
    logic rx_clk_s2_reg;
    logic rx_clk_s3_reg;
    logic tx_clk_s1_reg;
    logic tx_clk_s2_reg;
    logic tx_clk_s3_reg;
    logic [CG_W-1:0] rx_word_s1_reg;
    logic [CG_W-1:0] rx_word_s2_reg;
    logic [CG_W-1:0] rx_word_s3_reg;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            rx_rst_s1_reg <= 1'b1;
            rx_rst_s2_reg <= 1'b1;
            tx_rst_s1_reg <= 1'b1;
            tx_rst_s2_reg <= 1'b1;
        end else begin
            rx_rst_s1_reg <= RX_RESET_I;
            rx_rst_s2_reg <= rx_rst_s1_reg;
            tx_rst_s1_reg <= TX_RESET_I;
            tx_rst_s2_reg <= tx_rst_s1_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            rx_clk_s1_reg <= 1'b0;
            rx_clk_s2_reg <= 1'b0;
            rx_clk_s3_reg <= 1'b0;
            tx_clk_s1_reg <= 1'b0;
            tx_clk_s2_reg <= 1'b0;
            tx_clk_s3_reg <= 1'b0;
        end else begin
            rx_clk_s1_reg <= DBL_CODEGROUP_RX_CLOCK_I;
            rx_clk_s2_reg <= rx_clk_s1_reg;
            rx_clk_s3_reg <= rx_clk_s2_reg;
            tx_clk_s1_reg <= DBL_CODEGROUP_TX_CLOCK_I;
            tx_clk_s2_reg <= tx_clk_s1_reg;
            tx_clk_s3_reg <= tx_clk_s2_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        rx_word_s1_reg <= DBL_CODEGROUP_RX_WORD_I;
        rx_word_s2_reg <= rx_word_s1_reg;
        rx_word_s3_reg <= rx_word_s2_reg;
    end

    // domain resets: core reset or the synchronised party reset
    wire rx_rst_w = !RST_B_I || rx_rst_s2_reg;
    wire tx_rst_w = !RST_B_I || tx_rst_s2_reg;
    wire rx_edge_w = rx_clk_s2_reg & ~rx_clk_s3_reg;
    wire tx_edge_w = tx_clk_s2_reg & ~tx_clk_s3_reg;

    // status decode
    wire pa_link_w = PARTNER_ABILITY_I[PA_LINK_BIT];
    wire [1:0] pa_spd_w = PARTNER_ABILITY_I[PA_SPD_HI:PA_SPD_LO];
    wire pa_half_w = ~PARTNER_ABILITY_I[PA_DUPLEX_BIT];
    wire [1:0] spd_sel_w = AUTONEG_USE_BIT_I ? pa_spd_w : FORCED_SPEED_I;
    wire spd_ok_w = AUTONEG_USE_BIT_I ? pa_link_w : 1'b1;
    wire half_sel_w = AUTONEG_USE_BIT_I ? (pa_link_w & pa_half_w) : FORCED_DUPLEX_I;
    // a single two-bit selector keeps the three speeds exclusive
    wire set_1000_next = !SGMII_MODE_I || (spd_ok_w && spd_sel_w == SPD_1000);
    wire set_100_next = SGMII_MODE_I && spd_ok_w && spd_sel_w == SPD_100;
    wire set_10_next = SGMII_MODE_I && spd_ok_w && spd_sel_w == SPD_10;
    wire half_next = SGMII_MODE_I && half_sel_w;

    logic set_1000_reg;
    logic set_100_reg;
    logic set_10_reg;
    logic half_reg;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            set_1000_reg <= STATUS_RST;
            set_100_reg <= STATUS_RST;
            set_10_reg <= STATUS_RST;
            half_reg <= STATUS_RST;
        end else begin
            set_1000_reg <= set_1000_next;
            set_100_reg <= set_100_next;
            set_10_reg <= set_10_next;
            half_reg <= half_next;
        end
    end

    assign SET_1000_O = set_1000_reg;
    assign SET_100_O = set_100_reg;
    assign SET_10_O = set_10_reg;
    assign HALF_DUPLEX_IND_O = half_reg;

    // clock qualifiers, one per direction; full rate in 1000base-x or when sgmii gigabit is set
    wire full_rate_w = !SGMII_MODE_I || set_1000_reg;
    wire [QUAL_CNT_W-1:0] div_w = set_100_reg ? QUAL_CNT_W'(DIV_100 - 1) : QUAL_CNT_W'(DIV_10 - 1);
    wire [1:0] dom_rst_w = {tx_rst_w, rx_rst_w};
    logic [1:0] qual_w;

    for (genvar g = 0; g < 2; g++) begin : g_qual
        logic [QUAL_CNT_W-1:0] cnt_reg;
        logic qual_reg;
        wire wrap_w = (cnt_reg >= div_w);
        always_ff @(posedge CORE_CLK_I) begin
            if (dom_rst_w[g]) begin
                cnt_reg <= '0;
                qual_reg <= QUAL_RST;
            end else if (full_rate_w) begin
                cnt_reg <= '0;
                qual_reg <= 1'b1;
            end else begin
                cnt_reg <= wrap_w ? '0 : cnt_reg + 1'b1;
                qual_reg <= wrap_w;
            end
        end
        assign qual_w[g] = qual_reg;
    end

    assign RX_CLKENA_O = qual_w[0];
    assign TX_CLKENA_O = qual_w[1];

    // transmit path: user words buffered, two code groups per link clock
    sss_fifo_if #(.WIDTH(CG_W)) tx_if ();

    sss_fifo #(
        .WIDTH(CG_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(CORE_CLK_I),
        .clr_i(tx_rst_w),
        .port_if(tx_if.fifo)
    );

    assign tx_if.wr_valid = TX_VALID_I && !tx_rst_w;
    assign tx_if.wr_data = TX_DATA_I;
    assign tx_if.rd_ready = tx_edge_w && !tx_rst_w;
    assign TX_READY_O = tx_if.wr_ready && !tx_rst_w;

    logic [CG_W-1:0] tx_word_reg;
    // an empty buffer sends the fill word rather than stalling the link
    wire [CG_W-1:0] tx_word_next = tx_if.rd_valid ? tx_if.rd_data : TX_FILL_WORD;

    always_ff @(posedge CORE_CLK_I) begin
        if (tx_rst_w) begin
            tx_word_reg <= CG_RST_WORD;
        end else if (tx_edge_w) begin
            tx_word_reg <= tx_word_next;
        end
    end

    assign DBL_CODEGROUP_TX_WORD_O = tx_word_reg;

    // receive path: word sampled one core cycle before the seen edge,
    // so it is the value that stood while the link clock was still low
    logic [CG_W-1:0] rx_hold_reg;
    logic rx_pend_reg;
    logic [CG_W-1:0] rx_data_reg;
    logic rx_valid_reg;
    wire rx_emit_w = rx_pend_reg && qual_w[0];

    always_ff @(posedge CORE_CLK_I) begin
        if (rx_rst_w) begin
            rx_hold_reg <= CG_RST_WORD;
            rx_pend_reg <= 1'b0;
        end else begin
            if (rx_edge_w) begin
                rx_hold_reg <= rx_word_s3_reg;
            end
            // a new capture wins over the clear by emission
            rx_pend_reg <= rx_edge_w || (rx_pend_reg && !rx_emit_w);
        end
    end

    // slow qualifier spacing can let a newer word overwrite an unsent one
    always_ff @(posedge CORE_CLK_I) begin
        if (rx_rst_w) begin
            rx_data_reg <= CG_RST_WORD;
            rx_valid_reg <= 1'b0;
        end else begin
            rx_valid_reg <= rx_emit_w;
            if (rx_emit_w) begin
                rx_data_reg <= rx_hold_reg;
            end
        end
    end

    assign RX_DATA_O = rx_data_reg;
    assign RX_VALID_O = rx_valid_reg;

endmodule : sss_top
`default_nettype wire

// ==== testbench/sss_top_assertions.sv ====
/* port checker for sss_top, bound into every instance.
   assumes the small qualifier divisors of the bench (2 or more). */
`timescale 1ns/100ps
`default_nettype none
module sss_top_chk import sss_pkg::*; (
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic SGMII_MODE_I,
    input wire logic AUTONEG_USE_BIT_I,
    input wire logic [1:0] FORCED_SPEED_I,
    input wire logic FORCED_DUPLEX_I,
    input wire logic [PA_W-1:0] PARTNER_ABILITY_I,
    input wire logic SET_1000_O,
    input wire logic SET_100_O,
    input wire logic SET_10_O,
    input wire logic HALF_DUPLEX_IND_O,
    input wire logic RX_CLKENA_O,
    input wire logic TX_CLKENA_O,
    input wire logic RX_RESET_I,
    input wire logic TX_RESET_I,
    input wire logic DBL_CODEGROUP_TX_CLOCK_I,
    input wire logic [CG_W-1:0] DBL_CODEGROUP_TX_WORD_O,
    input wire logic TX_READY_O,
    input wire logic RX_VALID_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire logic sg_f = SGMII_MODE_I && !AUTONEG_USE_BIT_I;
    wire logic an_up = SGMII_MODE_I && AUTONEG_USE_BIT_I && PARTNER_ABILITY_I[PA_LINK_BIT];
    wire logic [1:0] an_spd = PARTNER_ABILITY_I[PA_SPD_HI:PA_SPD_LO];
    AST_BASEX_GIG: assert property (!SGMII_MODE_I |=> SET_1000_O)
        else $error("gigabit low in basex");
    AST_BASEX_LOW: assert property (!SGMII_MODE_I |=> !SET_100_O && !SET_10_O && !HALF_DUPLEX_IND_O)
        else $error("slow or half set in basex");
    AST_AN_GIG: assert property (an_up && an_spd == SPD_1000 |=> SET_1000_O)
        else $error("partner gigabit lost");
    AST_F_GIG: assert property (sg_f && FORCED_SPEED_I == SPD_1000 |=> SET_1000_O)
        else $error("forced gigabit lost");
    AST_F_100: assert property (sg_f && FORCED_SPEED_I == SPD_100 |=> SET_100_O)
        else $error("forced 100 lost");
    AST_F_10: assert property (sg_f && FORCED_SPEED_I == SPD_10 |=> SET_10_O)
        else $error("forced 10 lost");
    AST_F_HD: assert property (sg_f |=> HALF_DUPLEX_IND_O == $past(FORCED_DUPLEX_I))
        else $error("forced duplex wrong");
    AST_ONEHOT: assert property ($onehot0({SET_1000_O, SET_100_O, SET_10_O}))
        else $error("speed indicators overlap");
    // party resets clear the qualifiers, so the full-rate check waits them out
    AST_QUAL_FULL: assert property ((SET_1000_O && !RX_RESET_I && !TX_RESET_I) [*6] |-> RX_CLKENA_O && TX_CLKENA_O)
        else $error("qualifier gates at full rate");
    AST_QUAL_PULSE: assert property (SET_100_O [*6] ##0 RX_CLKENA_O |=> !RX_CLKENA_O)
        else $error("slow qualifier not a pulse");
    AST_RX_RST: assert property (RX_RESET_I [*5] |-> !RX_VALID_O && !RX_CLKENA_O)
        else $error("receive side alive in reset");
    AST_TX_RST: assert property (TX_RESET_I [*5] |-> !TX_READY_O && !TX_CLKENA_O && DBL_CODEGROUP_TX_WORD_O == CG_RST_WORD)
        else $error("transmit side alive in reset");
    AST_TX_EDGE: assert property (disable iff (!RST_B_I || TX_RESET_I)
        $changed(DBL_CODEGROUP_TX_WORD_O) |-> $past(DBL_CODEGROUP_TX_CLOCK_I, 3))
        else $error("tx word moved off link edge");
    AST_RX_PULSE: assert property (RX_VALID_O |=> !RX_VALID_O)
        else $error("rx valid longer than a cycle");
    AST_RX_GATE: assert property (RX_VALID_O |-> $past(RX_CLKENA_O))
        else $error("rx word emitted without qualifier");
    COV_FULL: cover property (!TX_READY_O && !TX_RESET_I);
    COV_RX: cover property (RX_VALID_O && SET_1000_O);
    COV_SLOW: cover property (SET_10_O && RX_CLKENA_O);
endmodule // sss_top_chk
bind sss_top sss_top_chk chk (.*);
`default_nettype wire

// ==== testbench/sss_serdes_model.sv ====
/* external serializer model: free-running link clocks, rx words, tx capture.
   assumes 160 ns link period and 20-bit double code-group words. */
`timescale 1ns/100ps
`default_nettype none
module sss_serdes_model import sss_pkg::*; (
    output logic tx_clk_o,
    output logic rx_clk_o,
    output logic [CG_W-1:0] rx_word_o,
    input wire logic [CG_W-1:0] tx_word_i
);
    logic [CG_W-1:0] last_rx;
    logic [CG_W-1:0] cap_q[$];
    logic [9:0] k;
    initial begin
        tx_clk_o = 1'b0;
        forever #80 tx_clk_o = ~tx_clk_o;
    end
    // data moves at the falling edge so it stands 80 ns around each rise
    initial begin
        rx_clk_o = 1'b0;
        k = 10'h001;
        rx_word_o = 20'h00000;
        #33;
        forever begin
            #80 rx_clk_o = 1'b1;
            last_rx = rx_word_o;
            #80 rx_clk_o = 1'b0;
            k = k + 10'h001;
            rx_word_o = {k, ~k};
        end
    end
    always @(posedge tx_clk_o) cap_q.push_back(tx_word_i);
endmodule // sss_serdes_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* top bench for sss_top: status tables, qualifier counts, tx buffer, rx capture.
   assumes the serializer model supplies both link clocks. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sss_pkg::*;
    localparam int D100 = 2;
    localparam int D10 = 4;
    logic clk, rst_b, sg, an, fdup, rxr, txr, tv, rx_chk;
    logic [1:0] fsp;
    logic [PA_W-1:0] pa;
    logic s1000, s100, s10, hd, rxe, txe, trdy, rxv, txc, rxc;
    logic [CG_W-1:0] txw, rxw, td, rxd;
    logic [CG_W-1:0] exp_q[$];
    int err_total, num_checks, n;
    sss_top #(.DIV_100(D100), .DIV_10(D10), .FIFO_DEPTH(16)) dut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
        .SGMII_MODE_I(sg), .AUTONEG_USE_BIT_I(an), .FORCED_SPEED_I(fsp), .FORCED_DUPLEX_I(fdup),
        .PARTNER_ABILITY_I(pa), .SET_1000_O(s1000), .SET_100_O(s100), .SET_10_O(s10),
        .HALF_DUPLEX_IND_O(hd), .RX_CLKENA_O(rxe), .TX_CLKENA_O(txe), .RX_RESET_I(rxr),
        .TX_RESET_I(txr), .DBL_CODEGROUP_TX_CLOCK_I(txc), .DBL_CODEGROUP_TX_WORD_O(txw),
        .DBL_CODEGROUP_RX_CLOCK_I(rxc), .DBL_CODEGROUP_RX_WORD_I(rxw), .TX_DATA_I(td),
        .TX_VALID_I(tv), .TX_READY_O(trdy), .RX_DATA_O(rxd), .RX_VALID_O(rxv));
    sss_serdes_model m (.tx_clk_o(txc), .rx_clk_o(rxc), .rx_word_o(rxw), .tx_word_i(txw));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cmp(input logic [CG_W-1:0] e, input logic [CG_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic st(input logic m_i, a, input logic [1:0] s, input logic d, input logic [PA_W-1:0] p,
        input logic [3:0] e);
        @(negedge clk);
        {sg, an, fsp, fdup, pa} = {m_i, a, s, d, p};
        repeat (2) @(negedge clk);
        cmp({16'h0000, e}, {16'h0000, s1000, s100, s10, hd});
    endtask
    // 40 cycles is a multiple of both divisors, so the count ignores phase
    task automatic qual(input logic [1:0] s, input int e);
        st(1'b1, 1'b0, s, 1'b0, 16'h0000, {s == SPD_1000, s == SPD_100, s == SPD_10, 1'b0});
        repeat (8) @(negedge clk);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += rxe + txe;
        end
        cmp(CG_W'(e), CG_W'(n));
    endtask
    // 80 core cycles span exactly ten 160 ns link periods, one rx word each
    task automatic rx_count(input int e);
        n = 0;
        repeat (80) begin
            @(negedge clk);
            n += rxv;
        end
        cmp(CG_W'(e), CG_W'(n));
    endtask
    always @(negedge clk) if (rx_chk && rxv === 1'b1) cmp(m.last_rx, rxd);
    initial begin
        {rst_b, sg, an, fdup, rxr, txr, tv, rx_chk, fsp, pa, td} = '0;
        err_total = 0;
        num_checks = 0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            st(1'b0, i[0], i[2:1], i[0], 16'hffff, 4'h8);
            st(1'b1, 1'b0, i[2:1], i[0], 16'h8800, {i[2:1] == SPD_1000, i[2:1] == SPD_100, i[2:1] == SPD_10, i[0]});
            st(1'b1, 1'b1, 2'h3, ~i[0], {4'h8 | {3'h0, ~i[0]}, i[2:1], 10'h000},
                {i[2:1] == SPD_1000, i[2:1] == SPD_100, i[2:1] == SPD_10, i[0]});
        end
        st(1'b1, 1'b1, 2'h2, 1'b1, 16'h0800, 4'h0);
        qual(SPD_100, 80 / D100);
        qual(SPD_10, 80 / D10);
        qual(SPD_1000, 80);
        st(1'b0, 1'b0, 2'h0, 1'b0, 16'h0000, 4'h8);
        repeat (20) @(negedge clk);
        rx_chk = 1'b1;
        m.cap_q.delete();
        n = 1;
        tv = 1'b1;
        repeat (60) begin
            td = {n[9:0], 10'h155};
            // ready is settled here and holds until the edge that takes td
            if (trdy === 1'b1) begin
                exp_q.push_back(td);
                n++;
            end
            @(negedge clk);
        end
        cmp(20'h00000, {19'h0, trdy});
        tv = 1'b0;
        repeat (200) @(negedge clk);
        foreach (m.cap_q[i]) if (m.cap_q[i] !== TX_FILL_WORD) cmp(exp_q.pop_front(), m.cap_q[i]);
        cmp(20'h00000, CG_W'(exp_q.size()));
        cmp(TX_FILL_WORD, txw);
        tv = 1'b1;
        td = 20'habcde;
        repeat (20) @(negedge clk);
        txr = 1'b1;
        repeat (5) @(negedge clk);
        cmp(CG_RST_WORD, txw);
        cmp(20'h00000, {18'h0, trdy, txe});
        txr = 1'b0;
        tv = 1'b0;
        repeat (40) @(negedge clk);
        cmp(TX_FILL_WORD, txw);
        rx_chk = 1'b0;
        rxr = 1'b1;
        repeat (5) @(negedge clk);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += rxv + rxe;
        end
        cmp(20'h00000, CG_W'(n));
        rxr = 1'b0;
        repeat (10) @(negedge clk);
        rx_chk = 1'b1;
        rx_count(10);
        // data check paused while the qualifier phase settles after the switch
        rx_chk = 1'b0;
        st(1'b1, 1'b0, SPD_10, 1'b0, 16'h0000, 4'h2);
        repeat (8) @(negedge clk);
        rx_chk = 1'b1;
        rx_count(10);
        test_done();
    end
    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
